// ===== sspsc_map.vh
// Register map, field positions, reset values and clock divider counts
// for the serial port control block.
// Assumes inclusion by bare name from the design files.
`ifndef SSPSC_MAP_VH
`define SSPSC_MAP_VH

// ---------------------------------------------------------------------
// Register word indices; the byte address is four times the index
// ---------------------------------------------------------------------
`define SSPSC_OFS_CTRL 6'h00
`define SSPSC_OFS_BUF 6'h01
`define SSPSC_OFS_IRQ_STAT 6'h02
`define SSPSC_OFS_IRQ_MASK 6'h03
`define SSPSC_OFS_STATE 6'h04

// ---------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------
`define SSPSC_CTRL_WRITE_COLLISION_FLAG 7
`define SSPSC_CTRL_OVF 6
`define SSPSC_CTRL_EN 5
`define SSPSC_CTRL_CKP 4
`define SSPSC_CTRL_MODE_HI 3
`define SSPSC_CTRL_MODE_LO 0
`define SSPSC_CTRL_RESET 8'h00

// ---------------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------------
`define SSPSC_MODE_DIV4 4'h0
`define SSPSC_MODE_DIV16 4'h1
`define SSPSC_MODE_DIV64 4'h2
`define SSPSC_MODE_TMR 4'h3
`define SSPSC_MODE_SLV_SS 4'h4
`define SSPSC_MODE_SLV_NOSS 4'h5

// ---------------------------------------------------------------------
// Interrupt status and state fields
// ---------------------------------------------------------------------
`define SSPSC_IRQ_DONE 0
`define SSPSC_IRQ_WRITE_COLLISION_FLAG 1
`define SSPSC_IRQ_OVF 2
`define SSPSC_IRQ_RESET 3'h0
`define SSPSC_ST_BF 0
`define SSPSC_ST_BUSY 1

// ---------------------------------------------------------------------
// Half periods of the serial clock in system clock cycles
// ---------------------------------------------------------------------
`define SSPSC_HALF_DIV4 6'h02
`define SSPSC_HALF_DIV16 6'h08
`define SSPSC_HALF_DIV64 6'h20
`define SSPSC_BITS 4'h8

`endif

// ===== sspsc_sync.v
// Two flip-flop synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps

module sspsc_sync #(
  parameter WIDTH = 3
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sspsc_sync

// ===== sspsc_top.v
// Control, status and SPI engine of the synchronous serial port,
// with an AHB-Lite register slave and one level interrupt.
// Assumes a single AHB-Lite master and pins driven from outside hclk.
`timescale 1ns/1ps
`include "sspsc_map.vh"

// Summary of operation
// R1 - Buffer write during shifting sets collision flag.
// R2 - Collision flag cleared only by software.
// R3 - Slave overrun sets overflow flag, drops byte.
// R4 - Enable bit hands pins to port.
// R5 - Disabled port releases pins to GPIO.
// R6 - Idle clock high when polarity one.
// R7 - Idle clock low when polarity zero.
// R8 - Master clock is oscillator over 4/16/64.
// R9 - Timer master; slave with/without select.
// R10 - Software sets pin directions correctly.
// R11 - Select disabled: select pin never gates.
module sspsc_top #(
  parameter DATA_BITS = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg irq,
  input wire timer_two_tick,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  input wire sdi_in,
  output reg sdo_out,
  output reg sdo_oe,
  input wire ss_n_in,
  output reg pins_owned
);

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  wire [2:0] pin_sync;
  wire sck_s;
  wire sdi_s;
  wire ss_n_s;

  sspsc_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({ss_n_in, sdi_in, sck_in}),
    .sync_out(pin_sync)
  );

  assign sck_s = pin_sync[0];
  assign sdi_s = pin_sync[1];
  assign ss_n_s = pin_sync[2];

  // -------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------
  reg write_collision_flag;
  reg receive_overflow_flag;
  reg port_enable_bit;
  reg clock_idle_polarity;
  reg [3:0] port_mode_select;
  reg [DATA_BITS-1:0] transfer_buffer;
  reg buf_full;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;

  // -------------------------------------------------------------------
  // Engine state
  // -------------------------------------------------------------------
  reg [DATA_BITS-1:0] shift_register;
  reg [3:0] bit_cnt;
  reg busy;
  reg rx_bit;
  reg sck_lvl;
  reg sck_prev;
  reg [5:0] div_cnt;

  // -------------------------------------------------------------------
  // AHB-Lite data phase tracking
  // -------------------------------------------------------------------
  reg ph_wr;
  reg ph_rd;
  reg [5:0] ph_idx;
  wire take;
  wire wr_ctrl;
  wire wr_buf;
  wire wr_stat;
  wire wr_mask;
  wire rd_buf;

  assign take = hsel & hready & htrans[1];
  assign wr_ctrl = ph_wr & (ph_idx == `SSPSC_OFS_CTRL);
  assign wr_buf = ph_wr & (ph_idx == `SSPSC_OFS_BUF);
  assign wr_stat = ph_wr & (ph_idx == `SSPSC_OFS_IRQ_STAT);
  assign wr_mask = ph_wr & (ph_idx == `SSPSC_OFS_IRQ_MASK);
  assign rd_buf = ph_rd & (ph_idx == `SSPSC_OFS_BUF);

  // -------------------------------------------------------------------
  // Mode decode
  // -------------------------------------------------------------------
  wire is_master;
  wire is_slave;
  wire ss_ctl;
  wire slv_gate;
  reg [5:0] half_cnt;

  // R9 - slave mode codes
  assign is_slave = port_enable_bit &
    ((port_mode_select == `SSPSC_MODE_SLV_SS) |
     (port_mode_select == `SSPSC_MODE_SLV_NOSS));
  assign is_master = port_enable_bit & (port_mode_select[3:2] == 2'b00);
  assign ss_ctl = (port_mode_select == `SSPSC_MODE_SLV_SS);
  // R11 - select ignored unless enabled
  assign slv_gate = is_slave & (~ss_ctl | ~ss_n_s);

  // R8 - divider half period select
  always @* begin
    case (port_mode_select)
      `SSPSC_MODE_DIV4: half_cnt = `SSPSC_HALF_DIV4;
      `SSPSC_MODE_DIV16: half_cnt = `SSPSC_HALF_DIV16;
      `SSPSC_MODE_DIV64: half_cnt = `SSPSC_HALF_DIV64;
      default: half_cnt = `SSPSC_HALF_DIV4;
    endcase
  end

  // -------------------------------------------------------------------
  // Serial clock edges
  // -------------------------------------------------------------------
  wire m_tick;
  wire lead_ev;
  wire trail_ev;
  wire s_lead;
  wire s_trail;
  wire last_bit;
  wire xfer_done;
  wire collide;
  wire rx_in;

  // R9 - timer output halved by toggling
  assign m_tick = busy & ((port_mode_select == `SSPSC_MODE_TMR) ? timer_two_tick :
    (div_cnt == half_cnt - 6'h01));
  assign s_lead = slv_gate & (sck_prev != sck_s) & (sck_s != clock_idle_polarity);
  assign s_trail = slv_gate & (sck_prev != sck_s) & (sck_s == clock_idle_polarity);
  assign lead_ev = is_master ? (m_tick & (sck_lvl == clock_idle_polarity)) : s_lead;
  assign trail_ev = is_master ? (m_tick & (sck_lvl != clock_idle_polarity)) : s_trail;
  assign last_bit = (bit_cnt == `SSPSC_BITS - 4'h1);
  assign xfer_done = trail_ev & last_bit;
  // R1 - write while a word is in flight
  assign collide = wr_buf & busy;
  // The data pin synchroniser lags by as much as the shortest half period,
  // so a master takes each bit at its trailing edge, the last moment before
  // the far slave moves on; a slave still takes it at the leading edge.
  assign rx_in = is_master ? sdi_s : rx_bit;

  // -------------------------------------------------------------------
  // Shift engine
  // -------------------------------------------------------------------
  // Disabling the port or leaving the SPI modes aborts any word in
  // flight; the half-shifted byte is lost without a flag.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_register <= {DATA_BITS{1'b0}};
      bit_cnt <= 4'h0;
      busy <= 1'b0;
      rx_bit <= 1'b0;
      sck_lvl <= 1'b0;
      sck_prev <= 1'b0;
      div_cnt <= 6'h00;
      sdo_out <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      if (!(is_master | is_slave)) begin
        busy <= 1'b0;
        bit_cnt <= 4'h0;
        div_cnt <= 6'h00;
        // R6 - idle level follows polarity
        sck_lvl <= clock_idle_polarity;
      end else if (wr_buf & !busy) begin
        shift_register <= hwdata[DATA_BITS-1:0];
        sdo_out <= hwdata[DATA_BITS-1];
        bit_cnt <= 4'h0;
        div_cnt <= 6'h00;
        busy <= is_master;
      end else begin
        if (is_master & busy) begin
          div_cnt <= m_tick ? 6'h00 : div_cnt + 6'h01;
        end
        if (is_master & m_tick) begin
          sck_lvl <= ~sck_lvl;
        end else if (!busy) begin
          // R7 - idle level follows polarity
          sck_lvl <= clock_idle_polarity;
        end
        // A slave deselected mid-byte restarts at the next selection.
        if (is_slave & ss_ctl & ss_n_s) begin
          bit_cnt <= 4'h0;
          busy <= 1'b0;
        end
        if (lead_ev) begin
          rx_bit <= sdi_s;
          busy <= 1'b1;
        end
        if (trail_ev) begin
          shift_register <= {shift_register[DATA_BITS-2:0], rx_in};
          sdo_out <= shift_register[DATA_BITS-2];
          bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
          if (last_bit) begin
            busy <= 1'b0;
          end
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Pin ownership
  // -------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      sdo_oe <= 1'b0;
      pins_owned <= 1'b0;
    end else begin
      // R4 - enabled port owns its pins
      // R5 - disabled port releases them
      pins_owned <= port_enable_bit;
      sck_out <= sck_lvl;
      sck_oe <= is_master;
      // R11 - select pin gates output only with control on
      sdo_oe <= is_master | (is_slave & (~ss_ctl | ~ss_n_s));
    end
  end

  // -------------------------------------------------------------------
  // Control register and receive buffer
  // -------------------------------------------------------------------
  wire ovf_ev;
  wire rx_load;

  // R3 - slave completion onto a full buffer
  assign ovf_ev = xfer_done & is_slave & buf_full;
  assign rx_load = xfer_done & ~ovf_ev;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_collision_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_enable_bit <= 1'b0;
      clock_idle_polarity <= 1'b0;
      port_mode_select <= 4'h0;
      transfer_buffer <= {DATA_BITS{1'b0}};
      buf_full <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        port_enable_bit <= hwdata[`SSPSC_CTRL_EN];
        clock_idle_polarity <= hwdata[`SSPSC_CTRL_CKP];
        port_mode_select <= hwdata[`SSPSC_CTRL_MODE_HI:`SSPSC_CTRL_MODE_LO];
      end
      // R1 - collision sets the flag
      // R2 - only a software write clears it
      if (collide) begin
        write_collision_flag <= 1'b1;
      end else if (wr_ctrl) begin
        write_collision_flag <= hwdata[`SSPSC_CTRL_WRITE_COLLISION_FLAG];
      end
      // R3 - overflow wins over a clearing write
      if (ovf_ev) begin
        receive_overflow_flag <= 1'b1;
      end else if (wr_ctrl) begin
        receive_overflow_flag <= hwdata[`SSPSC_CTRL_OVF];
      end
      // R3 - the new byte is discarded on overflow
      if (rx_load) begin
        transfer_buffer <= {shift_register[DATA_BITS-2:0], rx_in};
        buf_full <= 1'b1;
      end else if (rd_buf) begin
        buf_full <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Interrupt status, mask and output
  // -------------------------------------------------------------------
  wire [2:0] irq_set;

  assign irq_set = {ovf_ev, collide, xfer_done};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= `SSPSC_IRQ_RESET;
      irq_mask <= `SSPSC_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      // A new event beats a simultaneous write-one clear.
      irq_stat <= irq_set | (irq_stat & ~({3{wr_stat}} & hwdata[2:0]));
      if (wr_mask) begin
        irq_mask <= hwdata[2:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // -------------------------------------------------------------------
  // AHB-Lite slave
  // -------------------------------------------------------------------
  // Reads take one wait state so that read data is sampled after any
  // write of the previous data phase has landed.
  reg [31:0] rd_val;

  always @* begin
    case (ph_idx)
      `SSPSC_OFS_CTRL: rd_val = {24'h000000, write_collision_flag, receive_overflow_flag,
        port_enable_bit, clock_idle_polarity, port_mode_select};
      `SSPSC_OFS_BUF: rd_val = {{(32-DATA_BITS){1'b0}}, transfer_buffer};
      `SSPSC_OFS_IRQ_STAT: rd_val = {29'h00000000, irq_stat};
      `SSPSC_OFS_IRQ_MASK: rd_val = {29'h00000000, irq_mask};
      `SSPSC_OFS_STATE: rd_val = {30'h00000000, busy, buf_full};
      default: rd_val = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_idx <= 6'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      ph_wr <= take & hwrite;
      ph_rd <= take & ~hwrite;
      if (take) begin
        ph_idx <= haddr[7:2];
      end
      hreadyout <= ~(take & ~hwrite);
      if (ph_rd) begin
        hrdata <= rd_val;
      end
    end
  end

endmodule // sspsc_top

// ===== sspsc_checker.sv
// Assertions on the serial port control block ports.
// Assumes hready is looped back from hreadyout and hclk is the only clock.
`timescale 1ns/1ps
module sspsc_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire sck_out,
  input wire sck_oe,
  input wire sdo_oe,
  input wire ss_n_in,
  input wire pins_owned
);
  reg wr_pend;
  reg [7:0] ctl;
  reg [6:0] quiet;
  wire take = hsel && hready && htrans[1];
  wire master = ctl[5] && ctl[3:0] < 4'h4;
  // A shadow of the control word lets pin checks see what software asked for.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      ctl <= 8'h00;
      quiet <= 7'h00;
    end else begin
      wr_pend <= take && hwrite && haddr[7:2] == 6'h00;
      if (wr_pend) begin
        ctl <= hwdata[7:0];
      end
      if ($changed(sck_out) || $changed(ctl)) begin
        quiet <= 7'h00;
      end else if (quiet != 7'h7f) begin
        quiet <= quiet + 7'h01;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  pins_follow_a: assert property (pins_owned == $past(ctl[5]))
    else $error("pin ownership does not follow enable");
  off_quiet_a: assert property (!ctl[5] && $past(!ctl[5]) |-> !sck_oe && !sdo_oe)
    else $error("disabled port drives a pin");
  clk_drive_a: assert property (sck_oe == $past(master))
    else $error("clock drive does not follow master mode");
  half_period_a: assert property (sck_oe && ctl[3:0] != 4'h3 && $stable(ctl) &&
    $changed(sck_out) |=> $stable(sck_out)) else $error("serial clock half period too short");
  idle_level_a: assert property (quiet > 7'd40 && sck_oe && ctl[3:0] != 4'h3 |->
    sck_out == ctl[4]) else $error("idle clock level wrong");
  slave_release_a: assert property (ctl[5] && ctl[3:0] == 4'h4 && $past(ctl, 4) == ctl &&
    ss_n_in && $past(ss_n_in, 2) && $past(ss_n_in, 3) |-> !sdo_oe)
    else $error("deselected slave drives data");
  noss_drive_a: assert property (ctl[5] && ctl[3:0] == 4'h5 && $past(ctl) == ctl |-> sdo_oe)
    else $error("slave without select not driving");
endmodule // sspsc_checker

bind sspsc_top sspsc_checker sspsc_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out), .sck_oe(sck_oe),
  .sdo_oe(sdo_oe), .ss_n_in(ss_n_in), .pins_owned(pins_owned));

// ===== sspsc_spi_partner.sv
// Behavioural far-end SPI device: a slave for master-mode transfers,
// a master for slave-mode transfers. Assumes tasks are called from tb.
`timescale 1ns/1ps
module sspsc_spi_partner (
  input wire hclk,
  input wire sck_out,
  input wire sdo_out,
  output reg sck,
  output reg sdi,
  output reg ss_n
);
  reg [7:0] tx;
  reg [7:0] rx;
  reg cpol;
  reg mst;
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
    mst = 1'b0;
  end
  task arm(input [7:0] b, input p);
    begin
      tx = b;
      sdi = b[7];
      cpol = p;
      rx = 8'h00;
      mst = 1'b1;
    end
  endtask
  // slave role: sample data on each leading and shift it on each trailing serial clock edge
  // Like a real slave, data moves within the edge; leftover bits keep changing.
  always @(sck_out) if (mst) begin
    if (sck_out === ~cpol) rx = {rx[6:0], sdo_out};
    else begin
      tx = {tx[6:0], ~tx[0]};
      sdi = tx[7];
    end
  end
  task send(input [7:0] b, input use_ss, input p);
    integer i;
    begin
      mst = 1'b0;
      rx = 8'h00;
      ss_n <= ~use_ss;
      sck <= p;
      repeat (6) @(posedge hclk);
      for (i = 7; i >= 0; i = i - 1) begin
        sdi <= b[i];
        repeat (6) @(posedge hclk);
        sck <= ~p;
        rx = {rx[6:0], sdo_out};
        repeat (6) @(posedge hclk);
        sck <= p;
      end
      repeat (6) @(posedge hclk);
      ss_n <= 1'b1;
      sdi <= ~sdi;
      // Keep the slave deselected for a while before any next frame.
      repeat (6) @(posedge hclk);
    end
  endtask
endmodule // sspsc_spi_partner

// ===== tb.sv
// Self-checking bench for the serial port control block.
// Assumes the design map header is on the include path.
`timescale 1ns/1ps
`include "sspsc_map.vh"
module tb;
  reg hclk, hresetn, hsel, hwrite, sk_d, tick, tk_en;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] haddr, hwdata, rd;
  reg [7:0] b, g;
  wire hready, hresp, irq, sck_out, sck_oe, sdo_out, sdo_oe, pins_owned, sck, sdi, ss_n;
  wire [31:0] hrdata;
  integer num_errors, samples_checked, seed, i, m, pol, tg, gmin, gmax, cyc;
  sspsc_top sspsc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq), .timer_two_tick(tick),
    .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .ss_n_in(ss_n), .pins_owned(pins_owned));
  sspsc_spi_partner sspsc_spi_partner_i (.hclk(hclk), .sck_out(sck_out), .sdo_out(sdo_out),
    .sck(sck), .sdi(sdi), .ss_n(ss_n));
  task summarize;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [5:0] r, input [31:0] d);
    integer k;
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, r, 2'b00};
      k = 0;
      do begin @(posedge hclk); k = k + 1; end while (hready !== 1'b1 && k < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); k = k + 1; end while (hready !== 1'b1 && k < 50);
      rd = hrdata;
      if (k >= 50) begin num_errors = num_errors + 1; summarize; end
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      do begin bus(0, `SSPSC_OFS_STATE, 0); n = n + 1; end while (rd[1] !== 1'b0 && n < 300);
      if (n >= 300) begin num_errors = num_errors + 1; summarize; end
    end
  endtask
  // Half period in system clocks; the timer case follows the pulse spacing used here.
  function [31:0] exp_gap(input [3:0] md);
    exp_gap = (md == 4'h3) ? 32'd2 : (32'd2 << (2 * md));
  endfunction
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    sk_d <= sck_out;
    tick <= tk_en & ~tick;
    cyc <= cyc + 1;
    if (sck_out !== sk_d) begin
      tg <= tg + 1;
      cyc <= 1;
      if (tg > 0 && cyc < gmin) gmin <= cyc;
      if (tg > 0 && cyc > gmax) gmax <= cyc;
    end
  end
  initial begin
    seed = 32'hd7d570c4;
    num_errors = 0;
    samples_checked = 0;
    {hresetn, hsel, hwrite, sk_d, tick, tk_en, htrans, haddr, hwdata} = 0;
    hsize = 3'h2;
    {tg, cyc, gmin, gmax} = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      bus(0, i, 0);
      chk(rd, 0, "reset value");
    end
    bus(1, 6'h05, $random(seed));
    bus(0, 6'h05, 0);
    chk(rd, 0, "unmapped");
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, `SSPSC_OFS_CTRL, 32'h20 | (i << 4));
      repeat (3) @(posedge hclk);
      chk({sck_out, pins_owned, sck_oe}, 3'h3 | (i << 2), "idle enabled");
      bus(1, `SSPSC_OFS_CTRL, i << 4);
      repeat (3) @(posedge hclk);
      chk({pins_owned, sck_oe, sdo_oe}, 0, "released");
    end
    bus(1, `SSPSC_OFS_IRQ_MASK, 32'h7);
    for (m = 0; m < 4; m = m + 1) begin
      b = $random(seed);
      g = $random(seed);
      pol = $random(seed) & 1;
      bus(1, `SSPSC_OFS_CTRL, 32'h20 | (pol << 4) | m);
      tk_en <= (m == 3);
      // Let a polarity change of the idle clock be counted before the count restarts.
      repeat (4) @(posedge hclk);
      sspsc_spi_partner_i.arm(g, pol[0]);
      tg = 0;
      gmin = 255;
      gmax = 0;
      bus(1, `SSPSC_OFS_BUF, b);
      if (m == 0) bus(1, `SSPSC_OFS_BUF, ~b);
      wait_idle;
      repeat (3) @(posedge hclk);
      chk(tg, 16, "toggles");
      chk(gmin, exp_gap(m), "gap min");
      chk(gmax, exp_gap(m), "gap max");
      chk(sck_out, pol, "idle after");
      chk(sspsc_spi_partner_i.rx, b, "sent");
      bus(0, `SSPSC_OFS_BUF, 0);
      chk(rd, g, "received");
      if (m == 0) begin
        bus(0, `SSPSC_OFS_CTRL, 0);
        chk(rd, 8'ha0 | (pol << 4), "collision held");
        bus(1, `SSPSC_OFS_CTRL, 32'h20 | (pol << 4));
        bus(0, `SSPSC_OFS_CTRL, 0);
        chk(rd[7], 0, "collision cleared");
        bus(1, `SSPSC_OFS_IRQ_MASK, 0);
        repeat (2) @(posedge hclk);
        chk(irq, 0, "masked");
        bus(1, `SSPSC_OFS_IRQ_MASK, 32'h7);
      end
      bus(0, `SSPSC_OFS_IRQ_STAT, 0);
      chk(rd, (m == 0) ? 3 : 1, "events");
      chk(irq, 1, "irq raised");
      bus(1, `SSPSC_OFS_IRQ_STAT, 32'h7);
      repeat (2) @(posedge hclk);
      chk(irq, 0, "irq cleared");
    end
    tk_en <= 1'b0;
    for (m = 4; m < 6; m = m + 1) begin
      b = $random(seed);
      g = $random(seed);
      bus(1, `SSPSC_OFS_CTRL, 32'h20 | m);
      bus(1, `SSPSC_OFS_BUF, b);
      sspsc_spi_partner_i.send(g, m == 4, 1'b0);
      chk(sspsc_spi_partner_i.rx, b, "slave sent");
      sspsc_spi_partner_i.send(~g, m == 4, 1'b0);
      bus(0, `SSPSC_OFS_BUF, 0);
      chk(rd, g, "first kept");
      bus(0, `SSPSC_OFS_CTRL, 0);
      chk(rd, 8'h60 | m, "overflow");
      bus(0, `SSPSC_OFS_IRQ_STAT, 0);
      chk(rd[2], 1, "overflow event");
      bus(1, `SSPSC_OFS_IRQ_STAT, 32'h7);
    end
    summarize;
  end
endmodule // tb
